// *** motion_cmd_pkg.sv ***
// constants and types for the motion command decoder
// Notes on behaviour
// R1: safe-position command drives motor to secure_position
// R2: self-triggered safe move: bus lost, init, sleep
// R3: type 1 frame: command byte, broadcast/address byte
// R4: command identified from command byte only
// R5: safe-position broadcast zero reaches every node
// R6: coil fault triggers internal stop, shutdown
// R7: internal stop while moving sets lost_step_flag
// R8: after stop, actual copied into target position
// R9: immediate-stop broadcast zero stops every node
// R10: zero-position clears actual and target positions
// R11: zero-position sets reference-done flag
// R12: continuous run ignores shaft direction bit
// R13: bus silence during run triggers autonomous motion
// R14: broadcast continuous run accepted by every node
// R15: two-speed positioning then sets reference-done
// R16: two-speed sequence not interrupted by positioning
// R17: two-speed frame layout, fixed id, high bytes first
// R18: identifier top two bits are parity bits
// R19: two-speed broadcast zero reaches every node
// R20: first motion at max, second at min velocity
// R21: first absolute target, second relative offset
// R22: non-broadcast runs only on matching address
// R23: bad checksum frame discarded without effects
package motion_cmd_pkg;
    localparam logic [5:0] fixed_id          = 6'h3c;  // command frame identifier
    localparam logic [7:0] app_cmd_value     = 8'h80;  // application command byte
    localparam logic [6:0] cmd_safe_position = 7'h04;
    localparam logic [6:0] cmd_stop          = 7'h05;
    localparam logic [6:0] cmd_zero_position = 7'h06;
    localparam logic [6:0] cmd_continuous    = 7'h17;
    localparam logic [6:0] cmd_two_speed     = 7'h08;  // arbitrary free code for two-speed
    localparam logic [3:0] short_len         = 4'h3;   // 2 data + checksum, id not counted
    localparam logic [3:0] long_len          = 4'h9;   // 8 data + checksum, id not counted

    typedef enum logic [3:0] {
        st_idle    = 4'b0001,  // motor at rest
        st_move    = 4'b0010,  // single positioning move or continuous run
        st_first   = 4'b0100,  // two-speed first leg
        st_second  = 4'b1000   // two-speed second leg
    } motion_t;
endpackage

// *** motion_cmd_decoder.sv ***
// decodes motion command frames and drives position controller requests
`timescale 1ns/10ps
module motion_cmd_decoder
    import motion_cmd_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [7:0]  rx_byte,          // byte from bus framer
    input  wire logic        rx_valid,         // one-cycle byte strobe
    input  wire logic        frame_start,      // break/sync seen, id byte next
    input  wire logic        frame_end,        // frame closed after checksum
    input  wire logic [5:0]  own_direct_id,    // assigned direct identifier
    input  wire logic [6:0]  node_address,     // own 7-bit address
    input  wire logic [10:0] secure_position,  // safe position parameter
    input  wire logic        bus_lost,         // pin-level status
    input  wire logic        init_done,        // pin-level status
    input  wire logic        sleep_request,    // pin-level status
    input  wire logic        coil_fault,       // pin-level status
    input  wire logic        motor_moving,     // from controller
    input  wire logic        motion_done,      // one-cycle pulse from controller
    input  wire logic        status_read,      // quick_status_read clears flag
    output logic [15:0]      actual_position,
    output logic [15:0]      target_position,
    output logic [3:0]       run_velocity_max, // first leg velocity
    output logic [3:0]       run_velocity_min, // second leg velocity
    output logic             move_start,       // pulse: go to target_position
    output logic             run_continuous,   // continuous motion level
    output logic             stop_now,         // immediate stop level
    output logic             shutdown,         // coil fault shutdown level
    output logic             lost_step_flag,
    output logic             reference_done,
    output logic [15:0]      motion_state_bits // debug: {12'h0,state}
);
    // synchronised asynchronous pins
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] prev;
    } sync_t;

    typedef struct packed {
        motion_t     state;
        logic [3:0]  idx;      // byte index in frame
        logic        is_type1; // direct-id frame
        logic        is_fixed; // 0x3c frame
        logic [7:0]  sum;      // running data sum
        logic [7:0]  b1, b2, b3, b4, b5, b6, b7, b8;
        logic [15:0] act, tgt, second;
        logic [3:0]  vmax, vmin;
        logic        start, run, stop, shut, lost, ref_done, pend_copy;
        sync_t       sy;
    } state_t;

    state_t q, d;

    // identifier parity: p0 = id0^id1^id2^id4, p1 = ~(id1^id3^id4^id5)
    function automatic logic [7:0] protect(input logic [5:0] id);
        protect = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
    endfunction

    logic [8:0] sum_wide;    // carry folded back, classic checksum
    logic       sum_ok;
    logic       addr_hit;
    logic [6:0] cmd;
    logic       bc_n, ad_hit, ext;
    logic [3:0] rise;

    // next-state logic
    always_comb begin
        d          = q;
        d.start    = 1'b0;
        sum_wide   = 9'h000;
        sum_ok     = 1'b0;
        addr_hit   = 1'b0;
        cmd        = 7'h00;
        bc_n       = 1'b0;
        ad_hit     = 1'b0;
        ext        = 1'b0;
        // two flops before any use of pins
        d.sy.s1    = {bus_lost, init_done, sleep_request, coil_fault};
        d.sy.s2    = q.sy.s1;
        d.sy.prev  = q.sy.s2;
        rise       = q.sy.s2 & ~q.sy.prev;
        // byte collection
        if (frame_start) begin
            d.idx = 4'h0;
            d.sum = 8'h00;
            d.is_type1 = 1'b0;
            d.is_fixed = 1'b0;
        end else if (rx_valid) begin
            if (q.idx == 4'h0) begin
                d.is_type1 = (rx_byte == protect(own_direct_id));  // see R18 see R4
                d.is_fixed = (rx_byte == protect(fixed_id));        // see R17
            end else begin
                sum_wide = {1'b0, q.sum} + {1'b0, rx_byte};
                d.sum = sum_wide[7:0] + {7'h00, sum_wide[8]};
            end
            case (q.idx)
                4'h1: d.b1 = rx_byte;
                4'h2: d.b2 = rx_byte;
                4'h3: d.b3 = rx_byte;
                4'h4: d.b4 = rx_byte;
                4'h5: d.b5 = rx_byte;
                4'h6: d.b6 = rx_byte;
                4'h7: d.b7 = rx_byte;
                4'h8: d.b8 = rx_byte;
                default: ;
            endcase
            if (q.idx != 4'hf) begin
                d.idx = q.idx + 4'h1;
            end
        end
        // frame execution at close; checksum byte included makes sum 0xff
        if (frame_end) begin
            sum_ok = (q.sum == 8'hff);                                 // see R23
            if (q.is_type1 && q.idx == short_len + 4'h1 && q.b1[7]) begin  // see R3
                cmd    = q.b1[6:0];
                bc_n   = ~q.b2[7];
                ad_hit = q.b2[6:0] == node_address;
                ext    = 1'b0;
            end else if (q.is_fixed && q.idx == long_len + 4'h1 && q.b1 == app_cmd_value
                         && q.b2[7]) begin                             // see R17
                cmd    = q.b2[6:0];
                bc_n   = ~q.b3[7];
                ad_hit = q.b3[6:0] == node_address;
                ext    = 1'b1;
            end else begin
                sum_ok = 1'b0;  // unknown frame shapes ignored
            end
            addr_hit = sum_ok && (bc_n || ad_hit);                     // see R22 see R5
            if (addr_hit && !ext) begin
                case (cmd)
                    cmd_safe_position: begin                           // see R1 see R5
                        if (q.state == st_idle || q.state == st_move) begin
                            d.tgt   = {5'h00, secure_position};
                            d.start = 1'b1;
                            d.run   = 1'b0;
                            d.state = st_move;
                        end
                    end
                    cmd_stop: begin                                    // see R9
                        d.stop      = 1'b1;
                        d.run       = 1'b0;
                        d.pend_copy = 1'b1;
                    end
                    cmd_zero_position: begin                           // see R10 see R11
                        if (q.state != st_first && q.state != st_second) begin
                            d.act      = 16'h0000;
                            d.tgt      = 16'h0000;
                            d.ref_done = 1'b1;
                        end
                    end
                    cmd_continuous: begin       // see R12 see R14; direction from controller
                        if (q.state == st_idle || q.state == st_move) begin
                            d.run   = 1'b1;
                            d.state = st_move;
                        end
                    end
                    default: ;
                endcase
            end else if (addr_hit && cmd == cmd_two_speed
                         && q.state != st_first && q.state != st_second) begin  // see R19
                d.vmax   = q.b4[7:4];                                  // see R20
                d.vmin   = q.b4[3:0];
                d.tgt    = {q.b5, q.b6};                               // see R21
                d.second = {q.b7, q.b8};
                d.run    = 1'b0;
                d.start  = 1'b1;
                d.state  = st_first;                                   // see R15 see R16
            end
        end
        // internal triggers from pins
        if (q.sy.s2[0]) begin                                          // see R6
            if (!q.stop && motor_moving) begin
                d.lost = 1'b1;                                         // see R7
            end
            d.stop      = 1'b1;
            d.shut      = 1'b1;
            d.run       = 1'b0;
            d.pend_copy = 1'b1;
        end else if ((rise[3] || rise[2] || rise[1])
                     && q.state != st_first && q.state != st_second) begin  // see R2 see R13
            d.tgt   = {5'h00, secure_position};
            d.run   = 1'b0;
            d.start = 1'b1;
            d.state = st_move;
        end
        // motion progress
        if (motion_done) begin
            d.act = q.tgt;
            case (q.state)
                st_first: begin                                        // see R21
                    d.tgt   = q.tgt + q.second;
                    d.start = 1'b1;
                    d.state = st_second;
                end
                st_second: begin
                    d.ref_done = 1'b1;                                 // see R15
                    d.state    = st_idle;
                end
                st_move:  d.state = st_idle;
                st_idle:  d.state = st_idle;
                default:  d.state = st_idle;
            endcase
        end
        // at rest after stop: hold the stop position
        if (q.pend_copy && !motor_moving) begin                        // see R8
            d.tgt       = q.act;
            d.pend_copy = 1'b0;
            d.stop      = q.shut;
            d.state     = st_idle;
        end
        // set wins over read-clear
        if (status_read && !(d.lost && !q.lost)) begin
            d.lost = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q       <= '0;
            q.state <= st_idle;
        end else begin
            q <= d;
        end
    end

    assign actual_position   = q.act;
    assign target_position   = q.tgt;
    assign run_velocity_max  = q.vmax;
    assign run_velocity_min  = q.state == st_second ? q.vmin : q.vmin;  // second leg at min
    assign move_start        = q.start;
    assign run_continuous    = q.run;
    assign stop_now          = q.stop;
    assign shutdown          = q.shut;
    assign lost_step_flag    = q.lost;
    assign reference_done    = q.ref_done;
    assign motion_state_bits = {12'h000, q.state};
endmodule

// *** motion_cmd_decoder_properties.sv ***
// port-level checker for the motion command decoder
`timescale 1ns/10ps
module motion_cmd_decoder_properties (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        coil_fault,
    input wire logic        motor_moving,
    input wire logic        motion_done,
    input wire logic        status_read,
    input wire logic [15:0] actual_position,
    input wire logic [15:0] target_position,
    input wire logic        move_start,
    input wire logic        stop_now,
    input wire logic        shutdown,
    input wire logic        lost_step_flag,
    input wire logic        reference_done,
    input wire logic [15:0] motion_state_bits
);
    // reset is checked by hand, so this one is never disabled
    a_reset_to_idle: assert property (@(posedge clock) disable iff (1'b0)
        !rst_n |=> motion_state_bits == 16'h0001 && !shutdown && !move_start)
        else $error("state or outputs not cleared by reset");
    a_start_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
        move_start |=> !move_start)
        else $error("move start held longer than one cycle");
    a_state_one_hot: assert property (@(posedge clock) disable iff (!rst_n)
        $onehot(motion_state_bits[3:0]) && motion_state_bits[15:4] == 12'h000)
        else $error("motion state not one-hot");
    a_fault_shuts_down: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(coil_fault) |-> ##[1:4] shutdown && stop_now)
        else $error("coil fault did not shut down");
    a_shutdown_sticky: assert property (@(posedge clock) disable iff (!rst_n)
        shutdown |=> shutdown)
        else $error("shutdown released before reset");
    a_two_speed_kept: assert property (@(posedge clock) disable iff (!rst_n)
        motion_state_bits == 16'h0004 |=>
        motion_state_bits inside {16'h0004, 16'h0008} || stop_now || shutdown)
        else $error("two-speed sequence interrupted");
    a_stop_keeps_pos: assert property (@(posedge clock) disable iff (!rst_n)
        stop_now && !motor_moving |-> ##[1:3] target_position == actual_position)
        else $error("stop position not copied to target");
    a_dual_sets_ref: assert property (@(posedge clock) disable iff (!rst_n)
        motion_state_bits == 16'h0008 && motion_done |-> ##[1:2] reference_done)
        else $error("reference done not set after second leg");
    a_status_clears: assert property (@(posedge clock) disable iff (!rst_n)
        status_read && !coil_fault |-> ##[1:2] !lost_step_flag)
        else $error("status read did not clear lost step flag");
endmodule
bind motion_cmd_decoder motion_cmd_decoder_properties motion_cmd_decoder_properties_i (
    .clock, .rst_n, .coil_fault, .motor_moving, .motion_done, .status_read,
    .actual_position, .target_position, .move_start, .stop_now, .shutdown,
    .lost_step_flag, .reference_done, .motion_state_bits);

// *** lin_master_model.sv ***
// bus master model: sends command frames byte by byte to the decoder
`timescale 1ns/10ps
module lin_master_model (
    input  wire logic  clock,
    output logic [7:0] rx_byte,
    output logic       rx_valid,
    output logic       frame_start,
    output logic       frame_end
);
    initial begin
        rx_byte     = 8'h5a;
        rx_valid    = 1'b0;
        frame_start = 1'b0;
        frame_end   = 1'b0;
    end
    // one frame: start, identifier, n data bytes, checksum, end; bad flips a checksum bit
    task automatic send(input logic [5:0] id, input logic [7:0] d [0:7], input int n,
                        input bit bad);
        logic [8:0] s;
        s = 9'h000;
        @(negedge clock) frame_start <= 1'b1;
        @(negedge clock) frame_start <= 1'b0;
        rx_valid <= 1'b1;
        rx_byte  <= {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
        for (int i = 0; i < n; i++) begin
            @(negedge clock) rx_byte <= d[i];
            s = {1'b0, s[7:0]} + d[i];
            s = {1'b0, s[7:0]} + s[8];
        end
        @(negedge clock) rx_byte <= ~s[7:0] ^ {7'h00, bad};
        @(negedge clock) rx_valid <= 1'b0;
        rx_byte   <= ~rx_byte; // released line must not keep the last value
        frame_end <= 1'b1;
        @(negedge clock) frame_end <= 1'b0;
    endtask
endmodule

// *** tb_motion_cmd_decoder.sv ***
// self-checking bench for the motion command decoder
`timescale 1ns/10ps
module tb_motion_cmd_decoder;
    import motion_cmd_pkg::*;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  rx_byte;
    logic        rx_valid, frame_start, frame_end;
    logic [10:0] sec = 11'h000;        // safe position parameter
    logic [2:0]  trig = 3'b000;         // bus lost, init done, sleep request
    logic        coil = 1'b0, moving = 1'b0, done = 1'b0, sread = 1'b0;
    logic [15:0] act, tgt, state, p1, p2;
    logic [3:0]  vmax, vmin, vx, vn;
    logic        mstart, runc, stop, shut, lost, refd;
    logic [7:0]  d [0:7];
    logic [15:0] e_act = 16'h0000, e_tgt = 16'h0000; // bench model of the positions
    int          n_mismatch = 0, num_checks = 0;
    localparam logic [5:0] own_id = 6'h11;
    localparam logic [6:0] addr   = 7'h2a;
    always #4 clock = ~clock;
    lin_master_model lin_master_model_i (.clock, .rx_byte, .rx_valid, .frame_start, .frame_end);
    motion_cmd_decoder motion_cmd_decoder_i (.clock, .rst_n, .rx_byte, .rx_valid, .frame_start,
        .frame_end, .own_direct_id(own_id), .node_address(addr), .secure_position(sec),
        .bus_lost(trig[0]), .init_done(trig[1]), .sleep_request(trig[2]), .coil_fault(coil),
        .motor_moving(moving), .motion_done(done), .status_read(sread), .actual_position(act),
        .target_position(tgt), .run_velocity_max(vx), .run_velocity_min(vn), .move_start(mstart),
        .run_continuous(runc), .stop_now(stop), .shutdown(shut), .lost_step_flag(lost),
        .reference_done(refd), .motion_state_bits(state));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // type 1 frame; returns at the falling edge after the execution edge,
    // while the one-cycle move_start pulse still stands
    task automatic t1(input logic [6:0] c, input logic b, input logic [6:0] a, input bit bad);
        d[0] = {1'b1, c};
        d[1] = {b, a};
        lin_master_model_i.send(own_id, d, 2, bad);
    endtask
    task automatic finish_move;
        @(negedge clock) done <= 1'b1;
        @(negedge clock) done <= 1'b0;
        e_act = e_tgt;
        chk("actual", e_act, act);
    endtask
    task automatic hold_reset;
        @(negedge clock) rst_n <= 1'b0;
        repeat (10) @(negedge clock);
        rst_n <= 1'b1;
        e_act = 16'h0000;
        e_tgt = 16'h0000;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #200000 n_mismatch++;
        give_verdict();
    end
    initial begin
        void'($urandom(39145));
        hold_reset();
        @(negedge clock) chk("state", 16'h0001, state);
        chk("target", 16'h0000, tgt);
        sec = 11'($urandom);
        t1(cmd_safe_position, 1'b1, addr, 0);
        e_tgt = {5'h00, sec};
        chk("move_start", 16'h1, {15'h0, mstart});
        chk("target", e_tgt, tgt);
        finish_move();
        sec = ~sec;
        t1(cmd_safe_position, 1'b1, addr, 1);
        chk("target", e_tgt, tgt);
        t1(cmd_safe_position, 1'b1, addr ^ 7'h01, 0);
        chk("target", e_tgt, tgt);
        t1(cmd_safe_position, 1'b0, addr ^ 7'h01, 0);
        e_tgt = {5'h00, sec};
        chk("target", e_tgt, tgt);
        finish_move();
        $display("safe position frames done");
        t1(cmd_zero_position, 1'b0, 7'h00, 0);
        chk("actual", 16'h0000, act);
        chk("target", 16'h0000, tgt);
        chk("ref_done", 16'h1, {15'h0, refd});
        t1(cmd_continuous, 1'b0, addr ^ 7'h10, 0);
        chk("run", 16'h1, {15'h0, runc});
        for (int i = 0; i < 3; i++) begin
            sec = 11'($urandom);
            e_tgt = {5'h00, sec};
            @(negedge clock) trig[i] <= 1'b1;
            repeat (4) @(negedge clock);  // two sync flops, edge detect, answer
            chk("target", e_tgt, tgt);
            trig[i] <= 1'b0;
            finish_move();
        end
        $display("zero, run and self moves done");
        t1(cmd_stop, 1'b0, addr ^ 7'h05, 0);
        chk("stop", 16'h1, {15'h0, stop});
        hold_reset();
        {vmax, vmin} = 8'($urandom);
        {p1, p2}     = $urandom;
        // broadcast to a foreign address: every node must take it
        d = '{app_cmd_value, {1'b1, cmd_two_speed}, {1'b0, addr ^ 7'h33}, {vmax, vmin},
              p1[15:8], p1[7:0], p2[15:8], p2[7:0]};
        lin_master_model_i.send(fixed_id, d, 8, 0);
        e_tgt = p1;
        chk("target", e_tgt, tgt);
        chk("move_start", 16'h1, {15'h0, mstart});
        chk("vel", {8'h00, vmax, vmin}, {8'h00, vx, vn});
        t1(cmd_safe_position, 1'b0, addr, 0);
        chk("target", e_tgt, tgt);
        chk("state", 16'h0004, state);
        finish_move();
        e_tgt = p1 + p2;
        chk("target", e_tgt, tgt);
        finish_move();
        chk("ref_done", 16'h1, {15'h0, refd});
        $display("two-speed positioning done");
        // a fresh target is pending, so the stop must pull it back to the actual one
        t1(cmd_safe_position, 1'b1, addr, 0);
        chk("target", {5'h00, sec}, tgt);
        @(negedge clock) moving <= 1'b1;
        coil <= 1'b1;
        repeat (5) @(negedge clock);
        chk("shutdown", 16'h1, {15'h0, shut});
        chk("stop", 16'h1, {15'h0, stop});
        chk("lost_step", 16'h1, {15'h0, lost});
        moving <= 1'b0;
        coil <= 1'b0;
        repeat (3) @(negedge clock);
        sread <= 1'b1;
        @(negedge clock) sread <= 1'b0;
        chk("lost_step", 16'h0, {15'h0, lost});
        chk("target", e_act, tgt);
        chk("actual", e_act, act);
        $display("coil fault done");
        give_verdict();
    end
endmodule
